// [afacc_top.sv]
`timescale 1ns/10ps
// Operation
// - carry flag bit 7 set on carry out of add, on borrow of subtract
// - carry flag is operand and destination of bit operations
// - half carry flag bit 6 set on nibble carry of add, on nibble borrow of subtract
// - user flags bits 5 and 1 written only by software
// - bits 4 and 3 select active working-register bank
// - overflow bit 2 set when carry into and out of bit 7 differ
// - parity bit 0 always tracks odd ones count of main operand
// - eight-bit main operand register, primary accumulator
// - eight-bit second operand register, used by multiply and divide
module afacc_top (
	input  wire logic                hclk,
	input  wire logic                hresetn,
	input  wire logic                hsel,
	input  wire logic [31:0]         haddr,
	input  wire logic [1:0]          htrans,
	input  wire logic                hwrite,
	input  wire logic [2:0]          hsize,
	input  wire logic [31:0]         hwdata,
	input  wire logic                hready,
	output logic      [31:0]         hrdata,
	output logic                     hreadyout,
	output logic                     hresp,
	input  wire logic                op_valid,
	input  wire afacc_pkg::afacc_op_t op_code,
	input  wire logic [7:0]          op_data,
	input  wire logic                op_bit,
	output logic [7:0]               main_operand,
	output logic [7:0]               second_operand,
	output logic [7:0]               status_word,
	output logic                     bit_result,
	output logic [7:0]               bank_base
);
	import afacc_pkg::*;

	logic [7:0] status_r, status_nxt;
	logic [7:0] main_r, main_nxt;
	logic [7:0] second_r, second_nxt;
	logic       bitres_r, bitres_nxt;
	logic [7:0] bank_r, bank_nxt;
	logic       wr_pend_r, wr_pend_nxt;
	logic [7:0] wr_addr_r, wr_addr_nxt;
	logic [31:0] rdata_r, rdata_nxt;

	function automatic logic odd_parity(input logic [7:0] v);
		return ^v;
	endfunction

	function automatic logic [7:0] reg_read(input logic [7:0] a, input logic [7:0] s,
		input logic [7:0] m, input logic [7:0] b);
		logic [7:0] r;
		r = 8'h00;
		unique case (a)
			AFACC_STATUS_OFF: r = s;
			AFACC_MAIN_OFF:   r = m;
			AFACC_SECOND_OFF: r = b;
			default:          r = 8'h00;
		endcase
		return r;
	endfunction

	logic addr_ok;
	assign addr_ok = hsel && hready && (htrans == AFACC_HTRANS_NONSEQ || htrans == AFACC_HTRANS_SEQ);

	always_comb begin
		logic [8:0]  sum;
		logic [4:0]  nib;
		logic [7:0]  low7;
		logic        c_in;
		logic        c6;
		logic [15:0] prod;
		logic [7:0]  wb;
		logic [7:0]  st;
		sum = 9'h000;
		nib = 5'h00;
		low7 = 8'h00;
		c6 = 1'b0;
		prod = 16'h0000;
		wb = 8'h00;
		st = status_r;
		main_nxt = main_r;
		second_nxt = second_r;
		bitres_nxt = bitres_r;
		wr_pend_nxt = 1'b0;
		wr_addr_nxt = wr_addr_r;
		rdata_nxt = rdata_r;
		c_in = status_r[AFACC_CARRY_BIT];
		// bus write data phase lands first, core op may follow it
		if (wr_pend_r) begin
			wb = hwdata[7:0];
			unique case (wr_addr_r)
				AFACC_STATUS_OFF: st = {wb[7:1], st[AFACC_PARITY_BIT]};
				AFACC_MAIN_OFF:   main_nxt = wb;
				AFACC_SECOND_OFF: second_nxt = wb;
				default:          ;
			endcase
		end
		if (op_valid) begin
			unique case (op_code)
				AFACC_OP_ADD, AFACC_OP_ADDC, AFACC_OP_SUBB: begin
					// subtract as add of inverse with borrow folded in
					if (op_code == AFACC_OP_SUBB) begin
						sum = {1'b0, main_r} + {1'b0, ~op_data} + {8'h00, ~c_in};
						nib = {1'b0, main_r[3:0]} + {1'b0, ~op_data[3:0]} + {4'h0, ~c_in};
						low7 = {1'b0, main_r[6:0]} + {1'b0, ~op_data[6:0]} + {7'h00, ~c_in};
					end else begin
						c_in = (op_code == AFACC_OP_ADDC) ? status_r[AFACC_CARRY_BIT] : 1'b0;
						sum = {1'b0, main_r} + {1'b0, op_data} + {8'h00, c_in};
						nib = {1'b0, main_r[3:0]} + {1'b0, op_data[3:0]} + {4'h0, c_in};
						low7 = {1'b0, main_r[6:0]} + {1'b0, op_data[6:0]} + {7'h00, c_in};
					end
					c6 = low7[7];
					main_nxt = sum[7:0];
					st[AFACC_CARRY_BIT] = (op_code == AFACC_OP_SUBB) ? ~sum[8] : sum[8];
					st[AFACC_HALF_BIT] = (op_code == AFACC_OP_SUBB) ? ~nib[4] : nib[4];
					st[AFACC_OVF_BIT] = c6 ^ sum[8];
				end
				AFACC_OP_AND:  main_nxt = main_r & op_data;
				AFACC_OP_OR:   main_nxt = main_r | op_data;
				AFACC_OP_XOR:  main_nxt = main_r ^ op_data;
				AFACC_OP_LOAD: main_nxt = op_data;
				AFACC_OP_MUL: begin
					prod = main_r * second_r;
					main_nxt = prod[7:0];
					second_nxt = prod[15:8];
					st[AFACC_CARRY_BIT] = 1'b0;
					st[AFACC_OVF_BIT] = |prod[15:8];
				end
				AFACC_OP_DIV: begin
					st[AFACC_CARRY_BIT] = 1'b0;
					st[AFACC_OVF_BIT] = (second_r == 8'h00);
					if (second_r != 8'h00) begin
						main_nxt = main_r / second_r;
						second_nxt = main_r % second_r;
					end
				end
				AFACC_OP_BIT_SET_C: st[AFACC_CARRY_BIT] = 1'b1;
				AFACC_OP_BIT_CLR_C: st[AFACC_CARRY_BIT] = 1'b0;
				AFACC_OP_BIT_CPL_C: st[AFACC_CARRY_BIT] = ~status_r[AFACC_CARRY_BIT];
				AFACC_OP_BIT_ANL_C: st[AFACC_CARRY_BIT] = status_r[AFACC_CARRY_BIT] & op_bit;
				AFACC_OP_BIT_ORL_C: st[AFACC_CARRY_BIT] = status_r[AFACC_CARRY_BIT] | op_bit;
				AFACC_OP_BIT_MOV_C: bitres_nxt = status_r[AFACC_CARRY_BIT];
				default: ;
			endcase
		end
		st[AFACC_PARITY_BIT] = odd_parity(main_nxt);
		status_nxt = st;
		bank_nxt = 8'(st[AFACC_BANK_HI_BIT:AFACC_BANK_LO_BIT] * AFACC_BANK_SIZE);
		// bus address phase, zero wait states
		if (addr_ok) begin
			wr_pend_nxt = hwrite;
			wr_addr_nxt = haddr[7:0];
			if (!hwrite && haddr[31:8] == 24'h000000)
				rdata_nxt = {24'h000000, reg_read(haddr[7:0], status_r, main_r, second_r)};
			else if (!hwrite)
				rdata_nxt = 32'h00000000;
		end
		if (addr_ok && (haddr[31:8] != 24'h000000))
			wr_addr_nxt = 8'h00;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			status_r  <= AFACC_STATUS_RST;
			main_r    <= AFACC_MAIN_RST;
			second_r  <= AFACC_SECOND_RST;
			bitres_r  <= 1'b0;
			bank_r    <= 8'h00;
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
			rdata_r   <= 32'h00000000;
		end else begin
			status_r  <= status_nxt;
			main_r    <= main_nxt;
			second_r  <= second_nxt;
			bitres_r  <= bitres_nxt;
			bank_r    <= bank_nxt;
			wr_pend_r <= wr_pend_nxt;
			wr_addr_r <= wr_addr_nxt;
			rdata_r   <= rdata_nxt;
		end
	end

	// slave never stalls, always okay
	assign hreadyout      = 1'b1;
	assign hresp          = 1'b0;
	assign hrdata         = rdata_r;
	assign main_operand   = main_r;
	assign second_operand = second_r;
	assign status_word    = status_r;
	assign bit_result     = bitres_r;
	assign bank_base      = bank_r;
endmodule // afacc_top

// [afacc_pkg.sv]
package afacc_pkg;
	// register byte addresses
	localparam logic [7:0] AFACC_STATUS_OFF  = 8'hd0;
	localparam logic [7:0] AFACC_MAIN_OFF    = 8'he0;
	localparam logic [7:0] AFACC_SECOND_OFF  = 8'hf0;
	// status word field positions
	localparam int AFACC_CARRY_BIT   = 7;
	localparam int AFACC_HALF_BIT    = 6;
	localparam int AFACC_USER0_BIT   = 5;
	localparam int AFACC_BANK_HI_BIT = 4;
	localparam int AFACC_BANK_LO_BIT = 3;
	localparam int AFACC_OVF_BIT     = 2;
	localparam int AFACC_USER1_BIT   = 1;
	localparam int AFACC_PARITY_BIT  = 0;
	// reset values, undocumented so zero
	localparam logic [7:0] AFACC_STATUS_RST = 8'h00;
	localparam logic [7:0] AFACC_MAIN_RST   = 8'h00;
	localparam logic [7:0] AFACC_SECOND_RST = 8'h00;
	// working-register bank geometry
	localparam logic [7:0] AFACC_BANK_SIZE = 8'h08;
	// core operation codes
	typedef enum logic [3:0] {
		AFACC_OP_NONE,
		AFACC_OP_ADD,
		AFACC_OP_ADDC,
		AFACC_OP_SUBB,
		AFACC_OP_AND,
		AFACC_OP_OR,
		AFACC_OP_XOR,
		AFACC_OP_LOAD,
		AFACC_OP_MUL,
		AFACC_OP_DIV,
		AFACC_OP_BIT_SET_C,
		AFACC_OP_BIT_CLR_C,
		AFACC_OP_BIT_CPL_C,
		AFACC_OP_BIT_ANL_C,
		AFACC_OP_BIT_ORL_C,
		AFACC_OP_BIT_MOV_C
	} afacc_op_t;
	// ahb transfer types and word transfer size
	localparam logic [1:0] AFACC_HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] AFACC_HTRANS_SEQ    = 2'h3;
	localparam logic [2:0] AFACC_HSIZE_WORD    = 3'h2;
endpackage

// [afacc_chk.sv]
`timescale 1ns/10ps
module afacc_chk (
	input wire logic                 hclk,
	input wire logic                 hresetn,
	input wire logic                 hsel,
	input wire logic                 hresp,
	input wire logic                 op_valid,
	input wire afacc_pkg::afacc_op_t op_code,
	input wire logic [7:0]           op_data,
	input wire logic [7:0]           main_operand,
	input wire logic [7:0]           second_operand,
	input wire logic [7:0]           status_word,
	input wire logic [7:0]           bank_base
);
	import afacc_pkg::*;
	logic [8:0]  sum_r;
	logic [4:0]  nib_r;
	logic        x7_r;
	logic [15:0] prod_r;
	// operand sums, bit 7 xor and product kept one cycle for the checks
	always_ff @(posedge hclk) begin
		sum_r <= main_operand + op_data;
		nib_r <= main_operand[3:0] + op_data[3:0];
		x7_r <= main_operand[7] ^ op_data[7];
		prod_r <= main_operand * second_operand;
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence op_s(o);
		op_valid && op_code == o;
	endsequence
	AST_ADD_SUM: assert property (op_s(AFACC_OP_ADD) |=> {status_word[7], main_operand} == sum_r)
		else $error("add sum or carry wrong");
	AST_ADD_HALF: assert property (op_s(AFACC_OP_ADD) |=> status_word[6] == nib_r[4])
		else $error("half carry wrong");
	AST_ADD_OVF: assert property (op_s(AFACC_OP_ADD) |=> status_word[2] == ^{sum_r[8:7], x7_r})
		else $error("overflow wrong");
	AST_PARITY: assert property (status_word[0] == ^main_operand)
		else $error("parity wrong");
	AST_BANK: assert property (bank_base == {3'h0, status_word[4:3], 3'h0})
		else $error("bank base wrong");
	// a bus write landing with the op may move them
	AST_USER: assert property (op_valid && !$past(hsel) |=> $stable(status_word & 8'h22))
		else $error("user flags moved");
	AST_CPL: assert property (op_s(AFACC_OP_BIT_CPL_C) |=> $changed(status_word[7]))
		else $error("carry not complemented");
	AST_MUL: assert property (op_s(AFACC_OP_MUL) |=> {second_operand, main_operand} == prod_r)
		else $error("product wrong");
	AST_OKAY: assert property (!hresp)
		else $error("response not okay");
	cover property (op_s(AFACC_OP_ADD) ##1 status_word[7]);
	cover property (op_s(AFACC_OP_MUL));
	cover property (bank_base == 8'h18);
endmodule // afacc_chk
bind afacc_top afacc_chk u_chk (.*);

// [afacc_core_model.sv]
`timescale 1ns/10ps
module afacc_core_model (
	input wire logic             hclk,
	output afacc_pkg::afacc_op_t op_code,
	output logic                 op_valid,
	output logic [7:0]           op_data,
	output logic                 op_bit
);
	import afacc_pkg::*;
	initial begin
		op_valid = 1'b0;
		op_code = AFACC_OP_NONE;
		op_data = 8'h00;
		op_bit = 1'b0;
	end
	// g of one or more idle cycles models a slow core
	task automatic run(input afacc_op_t o, input logic [7:0] d, input logic b, input int g);
		op_valid <= 1'b1;
		op_code <= o;
		op_data <= d;
		op_bit <= b;
		@(posedge hclk);
		op_valid <= 1'b0;
		op_data <= ~d;
		op_bit <= ~b;
		repeat (g) @(posedge hclk);
	endtask
endmodule // afacc_core_model

// [afacc_tb_top.sv]
`timescale 1ns/10ps
module afacc_tb_top;
	import afacc_pkg::*;
	logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, rd_ph = 1'b0;
	logic        hreadyout, op_valid, op_bit;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
	logic [31:0] q[$];
	logic [7:0]  op_data, a, b, r;
	logic        bit_res;
	logic [8:0]  s;
	logic [4:0]  h;
	logic [15:0] m;
	afacc_op_t   op_code;
	int          err_total, total_checks, cyc;
	always #10 hclk = ~hclk;
	afacc_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(AFACC_HSIZE_WORD), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .op_valid(op_valid),
		.op_code(op_code), .op_data(op_data), .op_bit(op_bit), .main_operand(),
		.second_operand(), .status_word(), .bit_result(bit_res), .bank_base());
	afacc_core_model core (.hclk(hclk), .op_code(op_code), .op_valid(op_valid),
		.op_data(op_data), .op_bit(op_bit));
	task automatic bus(input logic [7:0] ad, input logic w, input logic [7:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, ad};
		hwrite <= w;
		htrans <= AFACC_HTRANS_NONSEQ;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		do @(posedge hclk); while (hreadyout !== 1'b1);
	endtask
	task automatic rd(input logic [7:0] ad, input logic [7:0] e);
		q.push_back({24'h0, e});
		bus(ad, 1'b0, 8'h00);
	endtask
	task automatic chk(input logic [31:0] e);
		total_checks++;
		if (hrdata !== e) begin
			err_total++;
			$display("unexpected hrdata exp %h got %h", e, hrdata);
		end
	endtask
	task automatic chk_bit(input logic e);
		total_checks++;
		if (bit_res !== e) begin
			err_total++;
			$display("unexpected bit_result exp %h got %h", e, bit_res);
		end
	endtask
	task automatic report_and_stop;
		if (err_total == 0 && total_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// read data is taken at the edge closing its data phase
	always @(posedge hclk) begin
		if (rd_ph) chk(q.pop_front());
		rd_ph = hsel && htrans[1] && !hwrite && hreadyout === 1'b1;
		cyc++;
		if (cyc == 4000) begin
			err_total++;
			report_and_stop();
		end
	end
	initial begin
		void'($urandom(78715));
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		rd(AFACC_STATUS_OFF, 8'h00);
		rd(AFACC_MAIN_OFF, 8'h00);
		rd(AFACC_SECOND_OFF, 8'h00);
		bus(8'hd4, 1'b1, 8'hff);
		rd(8'hd4, 8'h00);
		bus(AFACC_MAIN_OFF, 1'b1, 8'h07);
		rd(AFACC_STATUS_OFF, 8'h01);
		// parity write is dropped, hardware owns it
		for (int i = 0; i < 4; i++) begin
			bus(AFACC_STATUS_OFF, 1'b1, {3'h1, i[1:0], 3'h2});
			rd(AFACC_STATUS_OFF, {3'h1, i[1:0], 3'h3});
		end
		for (int i = 0; i < 8; i++) begin
			a = 8'($urandom);
			b = 8'($urandom);
			s = a + b + 9'(i[0]);
			h = a[3:0] + b[3:0] + 5'(i[0]);
			bus(AFACC_MAIN_OFF, 1'b1, a);
			bus(AFACC_STATUS_OFF, 1'b1, {i[0], 7'h22});
			core.run(i[0] ? AFACC_OP_ADDC : AFACC_OP_ADD, b, 1'b0, $urandom_range(3, 1));
			rd(AFACC_MAIN_OFF, s[7:0]);
			rd(AFACC_STATUS_OFF, {s[8], h[4], 3'h4, ^{s[8:7], a[7], b[7]}, 1'b1, ^s[7:0]});
		end
		m = a * b;
		bus(AFACC_MAIN_OFF, 1'b1, a);
		bus(AFACC_SECOND_OFF, 1'b1, b);
		core.run(AFACC_OP_MUL, 8'h00, 1'b0, 1);
		rd(AFACC_MAIN_OFF, m[7:0]);
		rd(AFACC_SECOND_OFF, m[15:8]);
		bus(AFACC_STATUS_OFF, 1'b1, 8'h00);
		core.run(AFACC_OP_BIT_CPL_C, 8'h00, 1'b0, 1);
		core.run(AFACC_OP_BIT_ANL_C, 8'h00, 1'b1, 2);
		rd(AFACC_STATUS_OFF, {1'b1, 6'h00, ^m[7:0]});
		core.run(AFACC_OP_BIT_MOV_C, 8'h00, 1'b0, 1);
		chk_bit(1'b1);
		core.run(AFACC_OP_BIT_CLR_C, 8'h00, 1'b0, 1);
		core.run(AFACC_OP_BIT_ORL_C, 8'h00, 1'b0, 1);
		core.run(AFACC_OP_BIT_MOV_C, 8'h00, 1'b0, 1);
		chk_bit(1'b0);
		core.run(AFACC_OP_BIT_SET_C, 8'h00, 1'b0, 1);
		core.run(AFACC_OP_BIT_MOV_C, 8'h00, 1'b0, 1);
		chk_bit(1'b1);
		// borrow semantics of subtract
		a = 8'($urandom);
		b = 8'($urandom);
		r = a - b;
		bus(AFACC_MAIN_OFF, 1'b1, a);
		bus(AFACC_STATUS_OFF, 1'b1, 8'h00);
		core.run(AFACC_OP_SUBB, b, 1'b0, 1);
		rd(AFACC_MAIN_OFF, r);
		rd(AFACC_STATUS_OFF, {a < b, a[3:0] < b[3:0], 3'h0, (a[7] ^ b[7]) & (r[7] ^ a[7]), 1'b0, ^r});
		core.run(AFACC_OP_LOAD, 8'h5a, 1'b0, 1);
		core.run(AFACC_OP_XOR, 8'hff, 1'b0, 1);
		core.run(AFACC_OP_AND, 8'h0f, 1'b0, 1);
		core.run(AFACC_OP_OR, 8'h30, 1'b0, 1);
		rd(AFACC_MAIN_OFF, 8'h35);
		r = a / (b | 8'h01);
		bus(AFACC_MAIN_OFF, 1'b1, a);
		bus(AFACC_SECOND_OFF, 1'b1, b | 8'h01);
		core.run(AFACC_OP_DIV, 8'h00, 1'b0, 1);
		rd(AFACC_MAIN_OFF, r);
		rd(AFACC_SECOND_OFF, a % (b | 8'h01));
		bus(AFACC_SECOND_OFF, 1'b1, 8'h00);
		bus(AFACC_STATUS_OFF, 1'b1, 8'h00);
		core.run(AFACC_OP_DIV, 8'h00, 1'b0, 1);
		rd(AFACC_STATUS_OFF, {5'h00, 1'b1, 1'b0, ^r});
		report_and_stop();
	end
endmodule // afacc_tb_top
